// File: verilog/esc_top.sv
// emergency stop input and configuration switch logic
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`include "esc_consts.svh"
`default_nettype none
module esc_top #(
    parameter int DEBOUNCE_CYC = `ESC_DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // switch bank, a one is a switch set on
    input wire esc_pkg::esc_sw_t switches_in,
    // stop contact, high while closed
    input wire logic halt_contact_in,
    // host stop command and release, one-cycle pulses
    input wire logic host_stop_cmd_in,
    input wire logic host_release_in,
    // raw limit sensor levels per axis
    input wire logic [1:0] limit_raw_in,
    // serial lines: host side and internal uart side
    input wire logic host_rxd_in,
    output logic host_txd_out,
    input wire logic uart_txd_in,
    output logic uart_rxd_out,
    // axi4-lite
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // results
    output logic halt_out,
    output logic [1:0] limit_active_out,
    output esc_pkg::esc_fmt_t fmt_out
);
    import esc_pkg::*;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // polarity: one means normally open, active when level high
    function automatic logic limit_hit(input logic level, input logic nopen);
        limit_hit = nopen ? level : !level;
    endfunction

    // stage value to polarity; nonzero stages use normally closed sensing
    function automatic logic stage_pol(input logic [7:0] stage, input logic sw);
        stage_pol = (stage == `ESC_STAGE_RST) ? sw : 1'b0;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    esc_sw_t sw_ff, nxt_sw;
    logic sw_taken_ff, nxt_sw_taken;
    esc_state_t st_ff, nxt_st;
    logic halt_ff, nxt_halt;
    logic [15:0] serfmt_ff, nxt_serfmt;
    logic [1:0] delim_ff, nxt_delim;
    logic [7:0] stage_ff, nxt_stage;
    logic [1:0] lim_ff, nxt_lim;
    esc_fmt_t fmt_ff, nxt_fmt;
    logic htx_ff, nxt_htx, urx_ff, nxt_urx;
    logic sw_stop_ff, nxt_sw_stop, sw_rel_ff, nxt_sw_rel;
    logic contact_ok;
    logic wr;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic wr_ok, rd_ok;

    // ------------------------------------------------------------------
    // contact filter
    // ------------------------------------------------------------------
    // debounced stop contact
    esc_debounce #(
        .CYCLES(DEBOUNCE_CYC)
    ) u_deb (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .raw_in(halt_contact_in),
        .clean_out(contact_ok)
    );

    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    esc_axil u_bus (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_out(wr),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data),
        .wr_strb_out(wr_strb),
        .wr_ok_in(wr_ok),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_ok_in(rd_ok)
    );

    // address map check
    always_comb begin
        wr_ok = (wr_addr <= `ESC_OFS_STAGE) && (wr_addr[1:0] == 2'h0);
        rd_ok = (rd_addr <= `ESC_OFS_LIMCFG) && (rd_addr[1:0] == 2'h0);
        rd_data = 32'h0000_0000;
        case (rd_addr)
            `ESC_OFS_CTRL: rd_data = 32'h0000_0000;
            `ESC_OFS_STATUS: rd_data = {28'h0000000, !contact_ok, 1'b0, st_ff == ESC_HALT,
                halt_ff};
            `ESC_OFS_SERFMT: rd_data = {16'h0000, serfmt_ff};
            `ESC_OFS_DELIM: rd_data = {30'h00000000, delim_ff};
            `ESC_OFS_STAGE: rd_data = {24'h000000, stage_ff};
            `ESC_OFS_LIMCFG: rd_data = {24'h000000, sw_ff};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // switch capture and stored settings
    // ------------------------------------------------------------------
    always_comb begin
        // capture once after reset release, then hold
        nxt_sw = sw_ff;
        nxt_sw_taken = 1'b1;
        if (!sw_taken_ff) begin
            nxt_sw = switches_in;
        end
        nxt_serfmt = serfmt_ff;
        nxt_delim = delim_ff;
        nxt_stage = stage_ff;
        nxt_sw_stop = 1'b0;
        nxt_sw_rel = 1'b0;
        if (wr && wr_strb[0]) begin
            case (wr_addr)
                `ESC_OFS_CTRL: begin
                    nxt_sw_stop = wr_data[`ESC_CTRL_CMD_STOP];
                    nxt_sw_rel = wr_data[`ESC_CTRL_RELEASE];
                end
                `ESC_OFS_SERFMT: nxt_serfmt = wr_data[15:0];
                `ESC_OFS_DELIM: nxt_delim = wr_data[1:0];
                `ESC_OFS_STAGE: nxt_stage = wr_data[7:0];
                default: nxt_stage = stage_ff;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            // every switch reads off until sampled
            sw_ff <= '0;
            sw_taken_ff <= 1'b0;
            serfmt_ff <= `ESC_SERFMT_RST;
            delim_ff <= `ESC_DELIM_RST;
            stage_ff <= `ESC_STAGE_RST;
            sw_stop_ff <= 1'b0;
            sw_rel_ff <= 1'b0;
        end else begin
            sw_ff <= nxt_sw;
            sw_taken_ff <= nxt_sw_taken;
            serfmt_ff <= nxt_serfmt;
            delim_ff <= nxt_delim;
            stage_ff <= nxt_stage;
            sw_stop_ff <= nxt_sw_stop;
            sw_rel_ff <= nxt_sw_rel;
        end
    end

    // ------------------------------------------------------------------
    // emergency stop machine
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ESC_RUN: begin
                // open contact halts only when enabled
                // host stop command has the same effect
                if ((sw_ff.halt_input_enable_switch && !contact_ok) || host_stop_cmd_in ||
                    sw_stop_ff) begin
                    nxt_st = ESC_HALT;
                end
            end
            ESC_HALT: begin
                if (host_release_in || sw_rel_ff) begin
                    nxt_st = ESC_RUN;
                end
            end
            default: nxt_st = ESC_RUN;
        endcase
        nxt_halt = (nxt_st == ESC_HALT);
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_ff <= ESC_RUN;
            halt_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            halt_ff <= nxt_halt;
        end
    end

    // ------------------------------------------------------------------
    // limits, framing and loopback
    // ------------------------------------------------------------------
    always_comb begin
        nxt_lim[0] = limit_hit(limit_raw_in[0],
            stage_pol(stage_ff, sw_ff.axis_a_limit_polarity_switch));
        nxt_lim[1] = limit_hit(limit_raw_in[1],
            stage_pol(stage_ff, sw_ff.axis_b_limit_polarity_switch));
        if (sw_ff.serial_framing_select_switch) begin
            nxt_fmt = {serfmt_ff, delim_ff};
        end else begin
            nxt_fmt = {`ESC_FIX_BAUD, 12'h000, `ESC_FIX_DELIM};
        end
        // raw line echo on the serial port only
        if (sw_ff.serial_loopback_switch) begin
            nxt_htx = host_rxd_in;
            nxt_urx = 1'b1;
        end else begin
            nxt_htx = uart_txd_in;
            nxt_urx = host_rxd_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            lim_ff <= 2'h0;
            fmt_ff <= {`ESC_FIX_BAUD, 12'h000, `ESC_FIX_DELIM};
            htx_ff <= 1'b1;
            urx_ff <= 1'b1;
        end else begin
            lim_ff <= nxt_lim;
            fmt_ff <= nxt_fmt;
            htx_ff <= nxt_htx;
            urx_ff <= nxt_urx;
        end
    end

    assign halt_out = halt_ff;
    assign limit_active_out = lim_ff;
    assign fmt_out = fmt_ff;
    assign host_txd_out = htx_ff;
    assign uart_rxd_out = urx_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_reset_no_halt: assert property (@(posedge sys_clk_in)
        $past(rst_in) |-> !halt_out) else $error("halt set right after reset");
    a_contact_ignored: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!sw_ff.halt_input_enable_switch && !host_stop_cmd_in && !sw_stop_ff && !halt_ff)
        |=> !halt_ff) else $error("halt without enable or command");
    a_contact_halts: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sw_ff.halt_input_enable_switch && !contact_ok) |=> halt_ff)
        else $error("open contact did not halt");
    a_cmd_halts: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        host_stop_cmd_in |=> halt_ff) else $error("host stop ignored");
    a_switch_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $past(sw_taken_ff) |-> $stable(sw_ff)) else $error("switches changed while running");
    a_fixed_frame: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(sw_ff.serial_framing_select_switch) ##0 sw_taken_ff |->
        fmt_out == {`ESC_FIX_BAUD, 12'h000, `ESC_FIX_DELIM}) else $error("fixed frame wrong");
    a_stored_frame: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $past(sw_ff.serial_framing_select_switch) |-> fmt_out == $past({serfmt_ff, delim_ff}))
        else $error("stored frame not used");
    a_loop_echo: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sw_ff.serial_loopback_switch |=> host_txd_out == $past(host_rxd_in) && uart_rxd_out)
        else $error("loopback echo wrong");
    a_limit_stage: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        stage_ff != 8'h00 && $stable(stage_ff) |=> limit_active_out[0] == !$past(limit_raw_in[0]))
        else $error("stage selection not applied");
endmodule
`default_nettype wire

// File: shared/esc_consts.svh
// timing counts, register offsets, field positions and reset values for the stop/switch block
`ifndef ESC_CONSTS_SVH
`define ESC_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ESC_OFS_CTRL 8'h00
`define ESC_OFS_STATUS 8'h04
`define ESC_OFS_SERFMT 8'h08
`define ESC_OFS_DELIM 8'h0c
`define ESC_OFS_STAGE 8'h10
`define ESC_OFS_LIMCFG 8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ESC_CTRL_CMD_STOP 0
`define ESC_CTRL_RELEASE 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ESC_SERFMT_RST 16'h2000
`define ESC_DELIM_RST 2'h0
`define ESC_STAGE_RST 8'h00
`define ESC_FIX_BAUD 4'h2
`define ESC_FIX_DELIM 2'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ESC_CLK_NS 10
`define ESC_DEBOUNCE_NS 100
`define ESC_DEBOUNCE_CYC ((`ESC_DEBOUNCE_NS + `ESC_CLK_NS - 1) / `ESC_CLK_NS)

`endif

// File: shared/esc_pkg.sv
// types shared by the stop/switch block
`default_nettype none
package esc_pkg;
    // sampled switch bank
    typedef struct packed {
        logic halt_input_enable_switch;
        logic serial_loopback_switch;
        logic serial_framing_select_switch;
        logic [2:0] unused;
        logic axis_b_limit_polarity_switch;
        logic axis_a_limit_polarity_switch;
    } esc_sw_t;

    // serial framing handed to the uart
    typedef struct packed {
        logic [3:0] baud_sel;
        logic [3:0] data_sel;
        logic [3:0] parity_sel;
        logic [3:0] stop_sel;
        logic [1:0] delim_sel;
    } esc_fmt_t;

    // stop machine states
    typedef enum logic [1:0] {
        ESC_RUN = 2'b01,
        ESC_HALT = 2'b10
    } esc_state_t;
endpackage
`default_nettype wire

// File: verilog/esc_debounce.sv
// synchroniser and debouncer for the mechanical stop contact
`default_nettype none
module esc_debounce #(
    parameter int CYCLES = 10
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // raw contact level and filtered result
    input wire logic raw_in,
    output logic clean_out
);
    logic sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic [15:0] cnt_ff, nxt_cnt;
    logic clean_ff, nxt_clean;

    // count while synchronised level differs from output
    always_comb begin
        nxt_sync1 = raw_in;
        nxt_sync2 = sync1_ff;
        nxt_cnt = 16'h0000;
        nxt_clean = clean_ff;
        if (sync2_ff != clean_ff) begin
            nxt_cnt = cnt_ff + 16'h0001;
            if (cnt_ff >= 16'(CYCLES - 1)) begin
                nxt_clean = sync2_ff;
                nxt_cnt = 16'h0000;
            end
        end
    end

    // registers; reset assumes a closed contact
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            cnt_ff <= 16'h0000;
            clean_ff <= 1'b1;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            cnt_ff <= nxt_cnt;
            clean_ff <= nxt_clean;
        end
    end

    assign clean_out = clean_ff;
endmodule
`default_nettype wire

// File: verilog/esc_axil.sv
// axi4-lite slave front end producing one-cycle register strobes
`default_nettype none
module esc_axil (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // axi4-lite
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register side
    output logic wr_out,
    output logic [7:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic [3:0] wr_strb_out,
    input wire logic wr_ok_in,
    output logic [7:0] rd_addr_out,
    input wire logic [31:0] rd_data_in,
    input wire logic rd_ok_in
);
    logic aw_ff, w_ff, b_ff, r_ff, nxt_aw, nxt_w, nxt_b, nxt_r;
    logic [7:0] awa_ff, nxt_awa, ara_ff, nxt_ara;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [3:0] ws_ff, nxt_ws;
    logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
    logic do_wr;
    logic awrdy_ff, wrdy_ff, ardy_ff, nxt_awrdy, nxt_wrdy, nxt_ardy;

    // write fires once address and data are both held
    assign do_wr = aw_ff && w_ff && !b_ff;
    assign wr_out = do_wr;
    assign wr_addr_out = awa_ff;
    assign wr_data_out = wd_ff;
    assign wr_strb_out = ws_ff;
    assign rd_addr_out = s_araddr;

    // channel state
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_b = b_ff;
        nxt_r = r_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_ws = ws_ff;
        nxt_br = br_ff;
        nxt_ara = ara_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (s_awvalid && !aw_ff) begin
            nxt_aw = 1'b1;
            nxt_awa = s_awaddr;
        end
        if (s_wvalid && !w_ff) begin
            nxt_w = 1'b1;
            nxt_wd = s_wdata;
            nxt_ws = s_wstrb;
        end
        if (do_wr) begin
            nxt_b = 1'b1;
            nxt_br = wr_ok_in ? 2'h0 : 2'h2;
        end
        if (b_ff && s_bready) begin
            nxt_b = 1'b0;
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
        end
        if (s_arvalid && !r_ff) begin
            nxt_r = 1'b1;
            nxt_ara = s_araddr;
            nxt_rd = rd_ok_in ? rd_data_in : 32'h0000_0000;
            nxt_rr = rd_ok_in ? 2'h0 : 2'h2;
        end else if (r_ff && s_rready) begin
            nxt_r = 1'b0;
        end
        // readies follow the next slot state so that they leave a flop
        nxt_awrdy = !nxt_aw;
        nxt_wrdy = !nxt_w;
        nxt_ardy = !nxt_r;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            b_ff <= 1'b0;
            r_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            ws_ff <= 4'h0;
            br_ff <= 2'h0;
            ara_ff <= 8'h00;
            rd_ff <= 32'h0000_0000;
            rr_ff <= 2'h0;
            awrdy_ff <= 1'b1;
            wrdy_ff <= 1'b1;
            ardy_ff <= 1'b1;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            b_ff <= nxt_b;
            r_ff <= nxt_r;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            ws_ff <= nxt_ws;
            br_ff <= nxt_br;
            ara_ff <= nxt_ara;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
            awrdy_ff <= nxt_awrdy;
            wrdy_ff <= nxt_wrdy;
            ardy_ff <= nxt_ardy;
        end
    end

    // ready is high while the channel slot is empty
    assign s_awready = awrdy_ff;
    assign s_wready = wrdy_ff;
    assign s_bvalid = b_ff;
    assign s_bresp = br_ff;
    assign s_arready = ardy_ff;
    assign s_rvalid = r_ff;
    assign s_rdata = rd_ff;
    assign s_rresp = rr_ff;
endmodule
`default_nettype wire

// File: sim/esc_far_model.sv
// far side model: stop contact and host serial terminal
`default_nettype none
module esc_far_model (
    // clock
    input wire logic sys_clk_in,
    // scenario controls
    input wire logic open_in,
    input wire logic send_in,
    input wire logic [7:0] char_in,
    // lines toward the block
    output logic contact_out,
    output logic rxd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] sh_ff = 10'h3ff;
    logic [9:0] nxt_sh;
    logic [3:0] cnt_ff = 4'h0;
    logic [3:0] nxt_cnt;
    // mechanical contact, high while closed
    assign contact_out = !open_in;
    // frame shifter: start bit, lsb first, stop bit
    always_comb begin
        nxt_sh = sh_ff >> 1;
        nxt_cnt = (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0;
        if (send_in) begin
            nxt_sh = {1'b1, char_in, 1'b0};
            nxt_cnt = 4'ha;
        end
    end
    // frame registers
    always_ff @(posedge sys_clk_in) begin
        sh_ff <= nxt_sh;
        cnt_ff <= nxt_cnt;
    end
    assign rxd_out = (cnt_ff != 4'h0) ? sh_ff[0] : 1'b1;
endmodule
`default_nettype wire

// File: sim/estop_and_switch_config_tb.sv
// self-checking bench for the stop input and switch block
`include "esc_consts.svh"
`default_nettype none
module estop_and_switch_config_tb import esc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in, rst_in, halt_contact_in, host_stop_cmd_in, host_release_in;
    logic host_rxd_in, host_txd_out, uart_txd_in, uart_rxd_out, halt_out;
    esc_sw_t switches_in;
    esc_fmt_t fmt_out;
    logic [1:0] limit_raw_in, limit_active_out, s_bresp, s_rresp, resp;
    logic [7:0] s_awaddr, s_araddr, char_c;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0] s_wstrb;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, open_c, send_c;
    int n_errors = 0;
    int n_checks = 0;
    esc_top #(.DEBOUNCE_CYC(2)) dut (.sys_clk_in, .rst_in, .switches_in, .halt_contact_in,
        .host_stop_cmd_in, .host_release_in, .limit_raw_in, .host_rxd_in, .host_txd_out,
        .uart_txd_in, .uart_rxd_out, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .halt_out, .limit_active_out,
        .fmt_out);
    esc_far_model far (.sys_clk_in, .open_in(open_c), .send_in(send_c), .char_in(char_c),
        .contact_out(halt_contact_in), .rxd_out(host_rxd_in));
    // 100 mhz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // ----
    // tasks
    // ----
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task expire;
        n_errors++;
        summarize;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task do_reset(input logic [7:0] sw);
        @(posedge sys_clk_in);
        switches_in <= sw;
        rst_in <= 1'b1;
        tick(2);
        rst_in <= 1'b0;
        tick(4);
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge sys_clk_in);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge sys_clk_in);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                resp = s_bresp;
                s_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) expire;
    endtask
    task axr(input logic [7:0] a);
        bit done;
        done = 0;
        @(posedge sys_clk_in);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge sys_clk_in);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                rd = s_rdata;
                resp = s_rresp;
                s_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) expire;
    endtask
    task wait_halt(input logic e);
        repeat (40) if (halt_out !== e) tick(1);
        chk(halt_out, e);
        if (halt_out !== e) expire;
    endtask
    task pulse(input logic stop);
        @(posedge sys_clk_in);
        if (stop) host_stop_cmd_in <= 1'b1;
        else host_release_in <= 1'b1;
        @(posedge sys_clk_in);
        host_stop_cmd_in <= 1'b0;
        host_release_in <= 1'b0;
    endtask
    // one host character while both line directions are compared
    task watch(input logic lb);
        logic prx, ptx;
        @(posedge sys_clk_in);
        char_c <= 8'ha5;
        send_c <= 1'b1;
        prx = host_rxd_in;
        ptx = uart_txd_in;
        repeat (12) begin
            @(posedge sys_clk_in);
            send_c <= 1'b0;
            uart_txd_in <= ~uart_txd_in;
            chk(host_txd_out, lb ? prx : ptx);
            chk(uart_rxd_out, lb ? 1'b1 : prx);
            prx = host_rxd_in;
            ptx = uart_txd_in;
        end
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        rst_in = 1'b1;
        switches_in = '0;
        {host_stop_cmd_in, host_release_in, open_c, send_c, s_awvalid, s_wvalid} = '0;
        {s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata, char_c} = '0;
        {uart_txd_in, limit_raw_in, s_wstrb} = {1'b1, 2'b00, 4'hf};
        do_reset(8'h00);
        chk(halt_out, 1'b0);
        chk(fmt_out, {4'h2, 12'h000, 2'h0});
        axr(`ESC_OFS_SERFMT);
        chk(rd, `ESC_SERFMT_RST);
        axr(`ESC_OFS_DELIM);
        chk(rd, 32'h0);
        axr(`ESC_OFS_LIMCFG);
        chk(rd, 32'h0);
        axr(8'h40);
        chk(resp, 2'h2);
        limit_raw_in <= 2'b01;
        tick(3);
        chk(limit_active_out, 2'b10);
        open_c <= 1'b1;
        tick(30);
        chk(halt_out, 1'b0);
        open_c <= 1'b0;
        watch(1'b0);
        $display("test defaults done");
        do_reset(8'ha1);
        switches_in <= 8'h00;
        axr(`ESC_OFS_LIMCFG);
        chk(rd, 32'ha1);
        chk(fmt_out, {4'h2, 12'h000, 2'h0});
        axw(`ESC_OFS_SERFMT, 32'h5123);
        axw(`ESC_OFS_DELIM, 32'h3);
        tick(3);
        chk(fmt_out, {16'h5123, 2'h3});
        chk(limit_active_out, 2'b11);
        axw(`ESC_OFS_STAGE, 32'h1);
        tick(3);
        chk(limit_active_out, 2'b10);
        axw(`ESC_OFS_STATUS, 32'h1);
        chk(resp, 2'h0);
        open_c <= 1'b1;
        tick(2);
        chk(halt_out, 1'b0);
        wait_halt(1'b1);
        open_c <= 1'b0;
        tick(8);
        chk(halt_out, 1'b1);
        pulse(1'b0);
        wait_halt(1'b0);
        pulse(1'b1);
        wait_halt(1'b1);
        axw(`ESC_OFS_CTRL, 32'h2);
        wait_halt(1'b0);
        axw(`ESC_OFS_CTRL, 32'h1);
        wait_halt(1'b1);
        axr(`ESC_OFS_STATUS);
        chk(rd, 32'h3);
        do_reset(8'ha1);
        chk(halt_out, 1'b0);
        $display("test stop and framing done");
        do_reset(8'h42);
        chk(limit_active_out, 2'b00);
        watch(1'b1);
        $display("test loopback done");
        summarize;
    end
endmodule
`default_nettype wire
